// *** core/epr_pcs_port.sv ***
// Purpose: Per-port coding sublayer control and latched status
// Assumes: Live link and sync inputs already synchronised
// Notes:   Status bits latch loss until read
`timescale 1ns/1ns
module epr_pcs_port (
    input  wire logic  clk_sys,
    input  wire logic  nrst,
    input  wire logic  rst_req,
    input  wire logic  stat_rd,
    input  wire logic  link_in,
    input  wire logic  sync_in,
    output logic [15:0] stat_word,
    output logic       pcs_rst
);
    import epr_pkg::*;

    logic [7:0] resync_ff;
    logic       link_lost_ff;
    logic       sync_lost_ff;
    logic       link_live;
    logic       sync_live;

    // Reset holds the sublayer down, then it must re-acquire
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            resync_ff <= 8'h00;
        else if (rst_req)
            resync_ff <= RESYNC_CYCLES;
        else if (resync_ff != 8'h00)
            resync_ff <= resync_ff - 8'h01;
    end

    assign pcs_rst   = (resync_ff != 8'h00);
    assign link_live = link_in & ~pcs_rst;
    assign sync_live = sync_in & ~pcs_rst;

    // A drop in the same cycle as the read stays latched
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            link_lost_ff <= 1'b0;
            sync_lost_ff <= 1'b0;
        end
        else
        begin
            link_lost_ff <= ~link_live | (link_lost_ff & ~stat_rd);
            sync_lost_ff <= ~sync_live | (sync_lost_ff & ~stat_rd);
        end
    end

    always_comb
    begin
        stat_word                 = 16'h0000;
        stat_word[STAT_LINK_BIT]  = link_live;
        stat_word[STAT_SYNC_BIT]  = sync_live;
        stat_word[STAT_LLOST_BIT] = link_lost_ff;
        stat_word[STAT_SLOST_BIT] = sync_lost_ff;
    end
endmodule

// *** core/epr_pkg.sv ***
// Purpose: Constants for the quad PHY management register portal
// Assumes: Clause 22 MDIO frames, 16-bit registers, four ports
// Notes:   Identity value below is arbitrary
package epr_pkg;
    localparam int          NPORT          = 4;
    localparam logic [4:0]  DEF_BASE_ADDR  = 5'h07;
    localparam logic [4:0]  REG_ID2        = 5'h03;
    localparam logic [4:0]  REG_EP_CTRL    = 5'h16;
    localparam logic [4:0]  REG_EP_DATA    = 5'h17;
    localparam logic [15:0] ID2_VALUE      = 16'h5a5a;
    localparam logic [4:0]  PCS_PAGE       = 5'h05;
    localparam logic [15:0] PCS_CTRL_REG   = 16'h0011;
    localparam logic [15:0] PCS_STAT_REG   = 16'h0012;
    localparam int          FUNC_HI        = 15;
    localparam int          FUNC_LO        = 14;
    localparam logic [1:0]  FUNC_ADDR      = 2'h0;
    localparam logic [1:0]  FUNC_DATA      = 2'h1;
    localparam int          PCS_RST_BIT    = 0;
    localparam int          STAT_LINK_BIT  = 2;
    localparam int          STAT_SYNC_BIT  = 0;
    localparam int          STAT_LLOST_BIT = 3;
    localparam int          STAT_SLOST_BIT = 1;
    localparam logic [7:0]  RESYNC_CYCLES  = 8'h40;
    localparam logic [1:0]  OP_WRITE       = 2'h1;
    localparam logic [1:0]  OP_READ        = 2'h2;
    localparam logic [5:0]  PREAMBLE_BITS  = 6'h20;
    localparam logic [5:0]  HDR_LAST_CNT   = 6'h0d;
    localparam logic [5:0]  TA_LAST_CNT    = 6'h01;
    localparam logic [5:0]  DATA_LAST_CNT  = 6'h0f;
    localparam logic [1:0]  STRAP_WAIT     = 2'h2;
endpackage

// *** core/epr_sync.sv ***
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Single clock domain downstream
// Notes:   First stage is read only by the second
`timescale 1ns/1ns
module epr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_ff <= '0;
            q       <= '0;
        end
        else
        begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

// *** core/epr_top.sv ***
// Purpose: MDIO slave for a quad PHY with extended-page portal
// Assumes: mdc is slow against clk_sys (at least 6 clk_sys per mdc, 3 in the low phase)
// Notes:   Clause 22 frames only; other registers read as zero
`timescale 1ns/1ns
module epr_top (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        mdc,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe,
    input  wire logic [4:0]  base_address_straps,
    input  wire logic [3:0]  link_in,
    input  wire logic [3:0]  sync_in,
    output logic [3:0]       pcs_rst,
    output logic [4:0]       base_addr
);
    import epr_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HDR  = 5'b00010,
        ST_TA   = 5'b00100,
        ST_RDAT = 5'b01000,
        ST_WDAT = 5'b10000
    } epr_state_t;

    epr_state_t  state_ff;
    logic        mdc_s;
    logic        mdio_s;
    logic [4:0]  straps_s;
    logic [3:0]  link_s;
    logic [3:0]  sync_s;
    logic        mdc_d_ff;
    logic        mdc_rise;
    logic        mdc_fall;
    logic [5:0]  ones_ff;
    logic [5:0]  cnt_ff;
    logic [13:0] hdr_ff;
    logic [15:0] sh_ff;
    logic [1:0]  strap_cnt_ff;
    logic [1:0]  port_sel;
    logic        port_hit;
    logic [4:0]  reg_sel;
    logic [15:0] ctrl_ff  [NPORT];
    logic [15:0] addr_ff  [NPORT];
    logic [3:0]  pcs_req;
    logic [3:0]  stat_rd;
    logic [15:0] stat_word [NPORT];
    logic [15:0] rd_word;
    logic        wr_go;
    logic        rd_go;
    logic        op_rd;

    function automatic logic data_phase(input logic [15:0] c);
        data_phase = (c[FUNC_HI:FUNC_LO] == FUNC_DATA);
    endfunction

    function automatic logic is_pcs(input logic [15:0] c, input logic [15:0] a,
                                    input logic [15:0] r);
        is_pcs = data_phase(c) && (c[4:0] == PCS_PAGE) && (a == r);
    endfunction

    epr_sync #(.W(1)) u_sync_mdc (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d       (mdc),
        .q       (mdc_s)
    );

    epr_sync #(.W(1)) u_sync_mdio (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d       (mdio_i),
        .q       (mdio_s)
    );

    epr_sync #(.W(5)) u_sync_strap (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d       (base_address_straps),
        .q       (straps_s)
    );

    epr_sync #(.W(4)) u_sync_link (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d       (link_in),
        .q       (link_s)
    );

    epr_sync #(.W(4)) u_sync_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d       (sync_in),
        .q       (sync_s)
    );

    // Straps caught once, after the synchroniser has filled; later pin changes ignored
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            base_addr    <= DEF_BASE_ADDR;
            strap_cnt_ff <= 2'h0;
        end
        else
        begin
            if (strap_cnt_ff <= STRAP_WAIT)
                strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff == STRAP_WAIT)
                base_addr <= straps_s;
        end
    end

    // Idle mdc is low, so the edge detector resets low to avoid a false edge
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            mdc_d_ff <= 1'b0;
        else
            mdc_d_ff <= mdc_s;
    end

    assign mdc_rise = mdc_s & ~mdc_d_ff;
    assign mdc_fall = ~mdc_s & mdc_d_ff;

    // Header: second start bit, op(2) phy(5) reg(5) shifted into hdr_ff; the first start bit ends the preamble
    assign port_sel = 2'(hdr_ff[9:5] - base_addr);
    assign port_hit = (5'(hdr_ff[9:5] - base_addr) < 5'(NPORT));
    assign reg_sel  = hdr_ff[4:0];
    assign op_rd    = (hdr_ff[11:10] == OP_READ);
    // Write lands on the last data rise; read word caught on the second turnaround rise
    assign wr_go    = (state_ff == ST_WDAT) && mdc_rise && (cnt_ff == DATA_LAST_CNT) && port_hit;
    assign rd_go    = (state_ff == ST_TA) && mdc_rise && (cnt_ff == TA_LAST_CNT)
                      && port_hit && op_rd;

    // Address-phase portal read returns the latched register number
    always_comb
    begin
        rd_word = 16'h0000;
        case (reg_sel)
            REG_ID2:     rd_word = ID2_VALUE;
            REG_EP_CTRL: rd_word = ctrl_ff[port_sel];
            REG_EP_DATA:
            begin
                if (!data_phase(ctrl_ff[port_sel]))
                    rd_word = addr_ff[port_sel];
                else if (is_pcs(ctrl_ff[port_sel], addr_ff[port_sel], PCS_STAT_REG))
                    rd_word = stat_word[port_sel];
            end
            default:     rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_IDLE;
            ones_ff  <= 6'h00;
            cnt_ff   <= 6'h00;
            hdr_ff   <= 14'h0000;
            sh_ff    <= 16'h0000;
        end
        else if (mdc_rise)
        begin
            case (state_ff)
                // Only a full run of preamble ones opens a frame
                ST_IDLE:
                begin
                    if (mdio_s)
                        ones_ff <= (ones_ff == PREAMBLE_BITS) ? ones_ff : ones_ff + 6'h01;
                    else
                    begin
                        ones_ff <= 6'h00;
                        if (ones_ff == PREAMBLE_BITS)
                        begin
                            state_ff <= ST_HDR;
                            hdr_ff   <= 14'h0000;
                            cnt_ff   <= 6'h01;
                        end
                    end
                end
                ST_HDR:
                begin
                    hdr_ff <= {hdr_ff[12:0], mdio_s};
                    cnt_ff <= cnt_ff + 6'h01;
                    if (cnt_ff == HDR_LAST_CNT)
                    begin
                        state_ff <= ST_TA;
                        cnt_ff   <= 6'h00;
                    end
                end
                ST_TA:
                begin
                    cnt_ff <= cnt_ff + 6'h01;
                    // Word loaded before the first data fall
                    if (rd_go)
                        sh_ff <= rd_word;
                    if (cnt_ff == TA_LAST_CNT)
                    begin
                        cnt_ff   <= 6'h00;
                        state_ff <= op_rd ? ST_RDAT : ST_WDAT;
                    end
                end
                ST_RDAT:
                begin
                    // Shift on every rise so the next fall shows the next bit;
                    // leaving on the last rise keeps the next preamble bit counted
                    sh_ff  <= {sh_ff[14:0], 1'b0};
                    cnt_ff <= cnt_ff + 6'h01;
                    if (cnt_ff == DATA_LAST_CNT)
                        state_ff <= ST_IDLE;
                end
                ST_WDAT:
                begin
                    sh_ff  <= {sh_ff[14:0], mdio_s};
                    cnt_ff <= cnt_ff + 6'h01;
                    if (cnt_ff == DATA_LAST_CNT)
                        state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Drive on falling mdc so the manager samples a settled bit
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            mdio_o  <= 1'b0;
            mdio_oe <= 1'b0;
        end
        else if (mdc_fall)
        begin
            // Second turnaround bit low, then the word MSB first
            if (state_ff == ST_TA && cnt_ff == TA_LAST_CNT && port_hit && op_rd)
            begin
                mdio_oe <= 1'b1;
                mdio_o  <= 1'b0;
            end
            else if (state_ff == ST_RDAT && port_hit)
            begin
                mdio_oe <= 1'b1;
                mdio_o  <= sh_ff[15];
            end
            else
            begin
                mdio_oe <= 1'b0;
                mdio_o  <= 1'b0;
            end
        end
    end

    // One portal and one sublayer per port; frames to other addresses never reach here
    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++)
        begin : g_port
            logic wr_me;
            logic [15:0] wdata;
            assign wr_me = wr_go && (port_sel == 2'(gp)) && (hdr_ff[11:10] == OP_WRITE);
            // Last data bit joins straight from the pin; the shift register holds the rest
            assign wdata = {sh_ff[14:0], mdio_s};

            always_ff @(posedge clk_sys or negedge nrst)
            begin
                if (!nrst)
                begin
                    ctrl_ff[gp] <= 16'h0000;
                    addr_ff[gp] <= 16'h0000;
                end
                else if (wr_me)
                begin
                    if (reg_sel == REG_EP_CTRL)
                        ctrl_ff[gp] <= wdata;
                    else if (reg_sel == REG_EP_DATA && !data_phase(ctrl_ff[gp]))
                        addr_ff[gp] <= wdata;
                end
            end

            // Write-through; the reset bit never stores, so it reads back zero
            assign pcs_req[gp] = wr_me && (reg_sel == REG_EP_DATA)
                                 && is_pcs(ctrl_ff[gp], addr_ff[gp], PCS_CTRL_REG)
                                 && wdata[PCS_RST_BIT];
            assign stat_rd[gp] = rd_go && (port_sel == 2'(gp)) && (reg_sel == REG_EP_DATA)
                                 && is_pcs(ctrl_ff[gp], addr_ff[gp], PCS_STAT_REG);

            epr_pcs_port u_pcs (
                .clk_sys   (clk_sys),
                .nrst      (nrst),
                .rst_req   (pcs_req[gp]),
                .stat_rd   (stat_rd[gp]),
                .link_in   (link_s[gp]),
                .sync_in   (sync_s[gp]),
                .stat_word (stat_word[gp]),
                .pcs_rst   (pcs_rst[gp])
            );
        end
    endgenerate
endmodule

// *** verification/epr_mgr_model.sv ***
// Purpose: Behavioural MDIO station manager
// Assumes: MDIO wire has a pull-up
// Notes:   mdc stands low between frames
`timescale 1ns/1ns
module epr_mgr_model
    import epr_pkg::*;
(
    input wire logic    clk_sys,
    input wire logic    mdio_w,
    output logic        mdc,
    output logic        mdo,
    output logic        mdo_en,
    output logic        rd_done,
    output logic [15:0] rd_data
);
    int half_cyc = 5;
    initial
    begin
        mdc = 1'b0;
        mdo = 1'b1;
        mdo_en = 1'b0;
        rd_done = 1'b0;
        rd_data = 16'h0;
    end
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] rg, input logic [15:0] wd);
        logic [63:0] f;
        logic        rd;
        f = {32'hffffffff, 2'b01, op, phy, rg, 2'b10, wd};
        rd = (op == OP_READ);
        for (int i = 63; i >= 0; i--)
        begin
            mdc = 1'b0;
            mdo = f[i];
            mdo_en = !(rd && i < 18);
            repeat (half_cyc) @(posedge clk_sys);
            #2 mdc = 1'b1;
            if (i < 16)
                rd_data[i] = mdio_w;
            repeat (half_cyc) @(posedge clk_sys);
            #2;
        end
        // Final fall lets the device let go
        mdc = 1'b0;
        mdo_en = 1'b0;
        rd_done = rd;
        @(posedge clk_sys);
        #2 rd_done = 1'b0;
        repeat (half_cyc) @(posedge clk_sys);
        #2;
    endtask
endmodule

// *** verification/epr_top_assertions.sv ***
// Purpose: Port checks for the MDIO register portal
// Assumes: Straps steady after reset
// Notes:   Bound into epr_top
`timescale 1ns/1ns
module epr_top_assertions
    import epr_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       mdc,
    input wire logic       mdio_o,
    input wire logic       mdio_oe,
    input wire logic [4:0] base_address_straps,
    input wire logic [3:0] pcs_rst,
    input wire logic [4:0] base_addr
);
    logic [3:0] up_ff;
    logic [7:0] hi_ff;
    logic [4:0] nf_ff;
    logic       mdc_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Raw mdc falls counted while driving
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            up_ff  <= 4'h0;
            hi_ff  <= 8'h0;
            nf_ff  <= 5'h0;
            mdc_ff <= 1'b0;
        end
        else
        begin
            up_ff  <= (up_ff == 4'hf) ? up_ff : up_ff + 4'h1;
            hi_ff  <= (pcs_rst == 4'h0) ? 8'h0 : hi_ff + 8'h1;
            nf_ff  <= !mdio_oe ? 5'h0 : nf_ff + {4'h0, mdc_ff & !mdc};
            mdc_ff <= mdc;
        end
    end
    AST_BASE_DEFAULT: assert property (up_ff == 4'h0 |-> base_addr == DEF_BASE_ADDR)
        else $error("base address not default after reset");
    AST_BASE_TAKEN: assert property (up_ff == 4'h6 |-> base_addr == base_address_straps)
        else $error("base address not taken from straps");
    AST_BASE_HOLD: assert property (up_ff > 4'h6 |-> $stable(base_addr))
        else $error("base address moved");
    AST_TA_LOW: assert property ($rose(mdio_oe) |-> !mdio_o)
        else $error("turnaround bit not low");
    AST_BIT_STANDS: assert property (mdc && $past(mdc) && $past(mdio_oe) |-> $stable(mdio_o) && mdio_oe)
        else $error("read bit changed while mdc high");
    AST_OE_LEN: assert property (nf_ff <= 5'h11)
        else $error("read drive too long");
    AST_PCS_LEN: assert property ($fell(|pcs_rst) |-> hi_ff == 8'h40)
        else $error("sublayer reset length wrong");
    AST_PCS_ONE: assert property ($onehot0(pcs_rst))
        else $error("more than one port in reset");
endmodule

bind epr_top epr_top_assertions u_chk (.clk_sys(clk_sys), .nrst(nrst), .mdc(mdc),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .base_address_straps(base_address_straps),
    .pcs_rst(pcs_rst), .base_addr(base_addr));

// *** verification/epr_top_test.sv ***
// Purpose: Self-checking bench for the MDIO register portal
// Assumes: Manager model drives mdc and its side of MDIO
// Notes:   Reads and sublayer resets checked from a note queue
`timescale 1ns/1ns
module epr_top_test;
    import epr_pkg::*;
    localparam logic [15:0] ST_OK   = (16'h1 << STAT_LINK_BIT) | (16'h1 << STAT_SYNC_BIT);
    localparam logic [15:0] ST_LOST = ST_OK | (16'h1 << STAT_LLOST_BIT) | (16'h1 << STAT_SLOST_BIT);
    logic        clk_sys;
    logic        nrst;
    logic        mdc;
    logic        mdo;
    logic        mdo_en;
    logic        mdio_o;
    logic        mdio_oe;
    logic        mdio_w;
    logic        rd_done;
    logic [15:0] rd_data;
    logic [4:0]  straps;
    logic [3:0]  link_in;
    logic [3:0]  sync_in;
    logic [3:0]  pcs_rst;
    logic [3:0]  pcs_q;
    logic [4:0]  base_addr;
    logic [15:0] notes[$];
    int          n_errors;
    int          checks_done;
    assign mdio_w = mdio_oe ? mdio_o : (mdo_en ? mdo : 1'b1);
    epr_top dut (.clk_sys(clk_sys), .nrst(nrst), .mdc(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o),
        .mdio_oe(mdio_oe), .base_address_straps(straps), .link_in(link_in),
        .sync_in(sync_in), .pcs_rst(pcs_rst), .base_addr(base_addr));
    epr_mgr_model mgr (.clk_sys(clk_sys), .mdio_w(mdio_w), .mdc(mdc), .mdo(mdo),
        .mdo_en(mdo_en), .rd_done(rd_done), .rd_data(rd_data));
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [15:0] got);
        logic [15:0] exp;
        exp = (notes.size() > 0) ? notes.pop_front() : 16'hxxxx;
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Outputs looked at mid-cycle, where they have settled
    always @(negedge clk_sys)
    begin
        pcs_q <= pcs_rst;
        if (rd_done === 1'b1)
            check(rd_data);
        if (pcs_rst !== pcs_q && pcs_q === 4'h0)
            check({12'h0, pcs_rst});
    end
    task automatic wr(input logic [4:0] a, input logic [4:0] r, input logic [15:0] d);
        mgr.frame(OP_WRITE, a, r, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [4:0] r, input logic [15:0] e);
        notes.push_back(e);
        mgr.frame(OP_READ, a, r, 16'h0);
    endtask
    task automatic do_reset(input logic [4:0] s);
        nrst = 1'b0;
        straps = s;
        repeat (10) @(posedge clk_sys);
        #2 nrst = 1'b1;
        repeat (6) @(posedge clk_sys);
        #2;
    endtask
    task automatic stat_rd(input logic [4:0] a, input logic [15:0] e);
        wr(a, REG_EP_CTRL, {11'h0, PCS_PAGE});
        wr(a, REG_EP_DATA, PCS_STAT_REG);
        wr(a, REG_EP_CTRL, {FUNC_DATA, 9'h0, PCS_PAGE});
        rd(a, REG_EP_DATA, e);
    endtask
    task automatic end_of_test;
        if (notes.size() != 0)
        begin
            n_errors++;
            $display("[FAIL] %0t expected result never seen", $time);
        end
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        $display("[FAIL] %0t timeout", $time);
        n_errors++;
        end_of_test;
    end
    initial
    begin
        int          p;
        logic [4:0]  b;
        logic [4:0]  a;
        n_errors = 0;
        checks_done = 0;
        link_in = 4'hf;
        sync_in = 4'hf;
        p = $urandom(32'h8a6ea5d0);
        do_reset(DEF_BASE_ADDR);
        for (int i = 0; i < NPORT; i++)
            rd(DEF_BASE_ADDR + 5'(i), REG_ID2, ID2_VALUE);
        rd(DEF_BASE_ADDR - 5'h1, REG_ID2, 16'hffff);
        rd(DEF_BASE_ADDR + 5'h4, REG_ID2, 16'hffff);
        wr(DEF_BASE_ADDR, REG_ID2, 16'($urandom));
        rd(DEF_BASE_ADDR, REG_ID2, ID2_VALUE);
        b = 5'($urandom % 28);
        do_reset(b);
        rd(b + 5'h3, REG_ID2, ID2_VALUE);
        p = $urandom % NPORT;
        a = b + 5'(p);
        mgr.half_cyc = 8;
        wr(a, REG_EP_CTRL, 16'h0005);
        wr(a, REG_EP_DATA, PCS_STAT_REG);
        rd(a, REG_EP_CTRL, 16'h0005);
        rd(a, REG_EP_DATA, PCS_STAT_REG);
        // Loss latched while the synchronisers still read low after reset
        stat_rd(a, ST_LOST);
        stat_rd(a, ST_OK);
        link_in[p] = 1'b0;
        sync_in[p] = 1'b0;
        repeat (10) @(posedge clk_sys);
        #2 link_in[p] = 1'b1;
        sync_in[p] = 1'b1;
        stat_rd(a, ST_LOST);
        stat_rd(a, ST_OK);
        mgr.half_cyc = 5;
        wr(a, REG_EP_CTRL, 16'h0005);
        wr(a, REG_EP_DATA, PCS_CTRL_REG);
        wr(a, REG_EP_CTRL, 16'h4005);
        notes.push_back({12'h0, 4'h1 << p});
        wr(a, REG_EP_DATA, 16'h0001);
        stat_rd(a, ST_LOST);
        stat_rd(a, ST_OK);
        end_of_test;
    end
endmodule
